// [hdl/edoc_ctrl.sv]
// Purpose: Host controller driving an extended-data-out DRAM through its pins.
// Assumes: 100 MHz clock; all pin outputs registered so strobes never glitch.
// Notes: Early writes only; read data returns after access time plus sync delay.
// Operation
// - Page activation lasts at least 50 ns and at most 100000 ns.
// - Outside page mode the row strobe stays active at most 10000 ns.
// - Row strobe precharge between cycles lasts at least 30 ns.
// - Write strobe falls at least 8 ns before column and row strobes rise.
// - Early write: write strobe low before column strobe, held 8 ns after.
// - Refresh: column strobe low 5 ns before row strobe, 8 ns after.
// - Either byte strobe may refresh; both used meet setup and hold.
// - Reads keep write strobe high until column or row strobe rises.
// - Row to column strobe 12 ns, row to column address 10 ns.
// - Every row refreshed within 64 ms.
// - Self-refresh needs row strobe active at least 100 us.
// - After self-refresh row strobe stays inactive at least 90 ns.
// - Write data setup and hold 8 ns from later strobe edge.
// - Lower strobe owns data bits 0-7, upper strobe bits 8-15.
// - Read-write cycles need write strobe delays of 30, 42, 67 ns.
// - Write data driven at least 13 ns after output drive goes off.
// - One page may mix read and write column cycles.
// - Addresses held at least 8 ns after their strobe falls.
// - Row strobe stays active 28 ns after last column precharge begins.
// - Each write strobe pulse lasts at least 8 ns.
// - After self-refresh, burst-refresh all rows before normal accesses.
// - After power-up wait 200 us, then eight cycles including refresh.
`timescale 1ns/1ps
`default_nettype none
module edoc_ctrl
    import edoc_pkg::*;
#(
    parameter int INIT_WAIT_CYC = C_INIT,
    parameter int SR_MIN_CYC = C_RASS,
    parameter int RASP_MAX_CYC = C_RASP_MAX,
    parameter int REF_INTERVAL_CYC = C_REF_INTERVAL,
    parameter int BURST_ROWS = ROWS
)(
    input wire logic clk,
    input wire logic nrst,
    input wire logic req_valid,
    output logic req_ready,
    input wire logic req_write,
    input wire logic [ROW_W-1:0] req_row,
    input wire logic [COL_W-1:0] req_col,
    input wire logic [1:0] req_be,
    input wire logic [DATA_W-1:0] req_wdata,
    output logic rsp_valid,
    output logic [DATA_W-1:0] rsp_rdata,
    input wire logic self_refresh_req,
    output logic self_refresh_active,
    output logic init_done,
    output logic row_strobe_n,
    output logic lower_byte_strobe_n,
    output logic upper_byte_strobe_n,
    output logic write_n,
    output logic out_en_n,
    output logic [ROW_W-1:0] addr,
    input wire logic [DATA_W-1:0] data_pins_i,
    output logic [DATA_W-1:0] data_pins_o,
    output logic data_pins_oe
);

    // ****************************************
    // Submodules
    // ****************************************
    edoc_ref_if ref_bus ();
    logic [DATA_W-1:0] pins_sync;

    edoc_ref_timer #(
        .INTERVAL_CYC(REF_INTERVAL_CYC)
    ) u_timer (
        .clk(clk),
        .nrst(nrst),
        .ref_port(ref_bus.timer)
    );

    edoc_pin_sync #(
        .WIDTH(DATA_W)
    ) u_sync (
        .clk(clk),
        .nrst(nrst),
        .pin(data_pins_i),
        .q(pins_sync)
    );

    // ****************************************
    // State
    // ****************************************
    edoc_state_t state;
    edoc_state_t next_state;
    logic [CNT_W-1:0] wait_cnt;
    logic [CNT_W-1:0] next_wait_cnt;
    logic [CNT_W-1:0] ras_cnt;
    logic [CNT_W-1:0] burst_left;
    logic [CNT_W-1:0] next_burst_left;
    logic sr_mode;
    logic next_sr_mode;
    logic sr_active;
    logic inited;
    logic cur_write;
    logic [ROW_W-1:0] cur_row;
    logic [COL_W-1:0] cur_col;
    logic [1:0] cur_be;
    logic [DATA_W-1:0] cur_wdata;

    // ****************************************
    // Decoding
    // ****************************************
    wire wait_done = (wait_cnt == '0);
    wire ras_min_met = (ras_cnt >= CNT_W'(C_RAS_MIN - 1));
    wire sr_min_met = (ras_cnt >= CNT_W'(SR_MIN_CYC - 1));
    wire burst_busy = (burst_left != '0);
    wire service_due = burst_busy | ref_bus.due | self_refresh_req;
    // The page limit keeps a margin so the last column cycle still fits.
    wire page_room = (ras_cnt < CNT_W'(RASP_MAX_CYC - PAGE_MARGIN));
    wire idle_ready = (state == S_IDLE) & inited & ~service_due;
    wire page_ready = (state == S_CPRE) & wait_done & ~service_due & page_room
        & (req_row == cur_row);
    wire accept = req_valid & req_ready;
    wire read_done = (state == S_CAS) & wait_done & ~cur_write;
    wire cas_done = (state == S_CAS) & wait_done;
    wire ref_start = (state == S_IDLE) & inited & service_due;
    wire ref_end = (state == S_REF) & (sr_mode ? (sr_min_met & ~self_refresh_req) : ras_min_met);

    assign req_ready = idle_ready | page_ready;
    assign ref_bus.ack = ref_start & ~self_refresh_req & ~burst_busy;

    // Pin levels decoded from the state, registered below.
    wire ras_d = ~((state == S_ROW) | (state == S_COLSET) | (state == S_CAS)
        | (state == S_CPRE) | (state == S_HOLD) | (state == S_REF));
    wire cbr_cas = (state == S_CSR) | (state == S_REF);
    wire lower_byte_strobe_n_d = ~(cbr_cas | ((state == S_CAS) & cur_be[0]));
    wire upper_byte_strobe_n_d = ~(cbr_cas | ((state == S_CAS) & cur_be[1]));
    // Write strobe spans column setup and the whole column pulse.
    wire wr_phase = cur_write & ((state == S_COLSET) | (state == S_CAS));
    wire we_d = ~wr_phase;
    wire oe_d = ~((state == S_CAS) & ~cur_write);
    wire [ROW_W-1:0] addr_d = (state == S_ROW) ? cur_row : ROW_W'(cur_col);

    // ****************************************
    // Sequencer
    // ****************************************
    always_comb
    begin
        next_state = state;
        next_wait_cnt = wait_done ? '0 : wait_cnt - 1'b1;
        next_burst_left = burst_left;
        next_sr_mode = sr_mode;
        case (state)
            S_INIT:
            begin
                if (wait_done)
                begin
                    next_state = S_IDLE;
                    next_burst_left = CNT_W'(INIT_CYCLES);
                end
            end
            S_IDLE:
            begin
                if (ref_start)
                begin
                    next_state = S_CSR;
                    next_sr_mode = self_refresh_req & ~burst_busy;
                    next_wait_cnt = CNT_W'(C_CSR - 1);
                end
                else if (accept)
                begin
                    next_state = S_ROW;
                    next_wait_cnt = CNT_W'(C_RAH - 1);
                end
            end
            S_ROW:
            begin
                if (wait_done)
                begin
                    next_state = S_COLSET;
                    next_wait_cnt = CNT_W'(C_COLSET - 1);
                end
            end
            S_COLSET:
            begin
                if (wait_done)
                begin
                    next_state = S_CAS;
                    next_wait_cnt = cur_write ? CNT_W'(C_CAS_WR - 1)
                        : CNT_W'(C_CAS_RD - 1);
                end
            end
            S_CAS:
            begin
                if (wait_done)
                begin
                    next_state = S_CPRE;
                    next_wait_cnt = CNT_W'(C_CPRE - 1);
                end
            end
            S_CPRE:
            begin
                if (wait_done)
                begin
                    if (accept)
                    begin
                        next_state = S_COLSET;
                        next_wait_cnt = '0;
                    end
                    else
                    begin
                        next_state = S_HOLD;
                        next_wait_cnt = CNT_W'(C_HOLD - 1);
                    end
                end
            end
            S_HOLD:
            begin
                if (wait_done & ras_min_met)
                begin
                    next_state = S_PRE;
                    next_wait_cnt = CNT_W'(C_RP - 1);
                end
            end
            S_PRE:
            begin
                if (wait_done)
                    next_state = S_IDLE;
            end
            S_CSR:
            begin
                if (wait_done)
                    next_state = S_REF;
            end
            S_REF:
            begin
                // The column strobes stay low for the whole refresh pulse.
                if (ref_end)
                begin
                    next_state = S_PRE;
                    next_sr_mode = 1'b0;
                    if (sr_mode)
                    begin
                        next_wait_cnt = CNT_W'(C_RPS - 1);
                        next_burst_left = CNT_W'(BURST_ROWS);
                    end
                    else
                    begin
                        next_wait_cnt = CNT_W'(C_RP - 1);
                        if (burst_busy)
                            next_burst_left = burst_left - 1'b1;
                    end
                end
            end
            default:
            begin
                next_state = S_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            state <= S_INIT;
            wait_cnt <= CNT_W'(INIT_WAIT_CYC - 1);
            burst_left <= '0;
            sr_mode <= 1'b0;
        end
        else
        begin
            state <= next_state;
            wait_cnt <= next_wait_cnt;
            burst_left <= next_burst_left;
            sr_mode <= next_sr_mode;
        end
    end

    // Counts cycles of row strobe activity, saturating at the top.
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            ras_cnt <= '0;
        else if (ras_d)
            ras_cnt <= '0;
        else if (ras_cnt != '1)
            ras_cnt <= ras_cnt + 1'b1;
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            sr_active <= 1'b0;
            inited <= 1'b0;
        end
        else
        begin
            sr_active <= (state == S_REF) & sr_mode & sr_min_met;
            if (state == S_IDLE)
                inited <= 1'b1;
        end
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            cur_write <= 1'b0;
            cur_row <= '0;
            cur_col <= '0;
            cur_be <= '0;
            cur_wdata <= '0;
        end
        else if (accept)
        begin
            cur_write <= req_write;
            cur_row <= req_row;
            cur_col <= req_col;
            cur_be <= req_be;
            cur_wdata <= req_wdata;
        end
    end

    // ****************************************
    // Pin and response registers
    // ****************************************
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            row_strobe_n <= 1'b1;
            lower_byte_strobe_n <= 1'b1;
            upper_byte_strobe_n <= 1'b1;
            write_n <= 1'b1;
            out_en_n <= 1'b1;
            addr <= '0;
            data_pins_o <= '0;
            data_pins_oe <= 1'b0;
        end
        else
        begin
            row_strobe_n <= ras_d;
            lower_byte_strobe_n <= lower_byte_strobe_n_d;
            upper_byte_strobe_n <= upper_byte_strobe_n_d;
            write_n <= we_d;
            out_en_n <= oe_d;
            addr <= addr_d;
            data_pins_o <= cur_wdata;
            data_pins_oe <= wr_phase;
        end
    end

    // Sampling ends the read before the row strobe can rise, so turn-off never matters.
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            rsp_valid <= 1'b0;
            rsp_rdata <= '0;
        end
        else
        begin
            rsp_valid <= cas_done;
            if (read_done)
                rsp_rdata <= pins_sync;
        end
    end

    assign self_refresh_active = sr_active;
    assign init_done = inited & ~burst_busy;

endmodule : edoc_ctrl
`default_nettype wire

// [hdl/edoc_pin_sync.sv]
// Purpose: Three-stage synchroniser for the data pins read back from the DRAM.
// Assumes: Data is stable while the column strobe is held low.
// Notes: A bit changes once the second and third stages agree.
`timescale 1ns/1ps
`default_nettype none
module edoc_pin_sync #(
    parameter int WIDTH = 16
)(
    input wire logic clk,
    input wire logic nrst,
    input wire logic [WIDTH-1:0] pin,
    output logic [WIDTH-1:0] q
);
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            s1 <= '0;
            s2 <= '0;
            s3 <= '0;
        end
        else
        begin
            s1 <= pin;
            s2 <= s1;
            s3 <= s2;
        end
    end

    for (genvar i = 0; i < WIDTH; i++)
    begin : g_bit
        always_ff @(posedge clk or negedge nrst)
        begin
            if (!nrst)
                q[i] <= 1'b0;
            else if (s2[i] == s3[i])
                q[i] <= s3[i];
        end
    end
endmodule : edoc_pin_sync
`default_nettype wire

// [hdl/edoc_pkg.sv]
// Purpose: Shared constants for the extended-data-out DRAM controller.
// Assumes: 100 MHz clock; timing figures of the faster speed grade.
// Notes: Each cycle count except PAGE_MARGIN and SYNC_LAT is derived from a time in nanoseconds, microseconds or milliseconds.
package edoc_pkg;

    // ****************************************
    // Clock and widths
    // ****************************************
    localparam int CLK_NS = 10;
    localparam int ROW_W = 12;
    localparam int COL_W = 10;
    localparam int DATA_W = 16;
    localparam int CNT_W = 16;
    localparam int SYNC_LAT = 4;

    // ****************************************
    // Times in nanoseconds, microseconds and milliseconds
    // ****************************************
    localparam int T_RAS_MIN_NS = 50;
    localparam int T_RASP_MAX_NS = 100000;
    localparam int T_RAS_MAX_NS = 10000;
    localparam int T_RP_NS = 30;
    localparam int T_RAH_NS = 8;
    localparam int T_RCD_NS = 12;
    localparam int T_CAS_NS = 8;
    localparam int T_CP_NS = 8;
    localparam int T_OED_NS = 13;
    localparam int T_RHCP_NS = 28;
    localparam int T_RAC_NS = 50;
    localparam int T_CSR_NS = 5;
    localparam int T_CHR_NS = 8;
    localparam int T_RPS_NS = 90;
    localparam int T_WP_NS = 8;
    localparam int T_REF_MS = 64;
    localparam int T_INIT_US = 200;
    localparam int T_RASS_US = 100;

    // ****************************************
    // Cycle counts: least times round up, longest times round down
    // ****************************************
    localparam int C_RAS_MIN = (T_RAS_MIN_NS + CLK_NS - 1) / CLK_NS;
    localparam int C_RASP_MAX = T_RASP_MAX_NS / CLK_NS;
    localparam int C_RAS_MAX = T_RAS_MAX_NS / CLK_NS;
    localparam int C_RP = (T_RP_NS + CLK_NS - 1) / CLK_NS;
    localparam int C_RAH = (T_RAH_NS + CLK_NS - 1) / CLK_NS;
    localparam int C_RCD = (T_RCD_NS + CLK_NS - 1) / CLK_NS;
    localparam int C_COLSET = (C_RCD > C_RAH) ? C_RCD - C_RAH : 1;
    localparam int C_WP = (T_WP_NS + CLK_NS - 1) / CLK_NS;
    localparam int C_CAS_WR = ((T_CAS_NS > T_WP_NS ? T_CAS_NS : T_WP_NS) + CLK_NS - 1)
        / CLK_NS;
    localparam int C_RAC = (T_RAC_NS + CLK_NS - 1) / CLK_NS;
    localparam int C_CAS_RD = C_RAC + SYNC_LAT;
    localparam int C_CPRE = ((T_OED_NS > T_CP_NS ? T_OED_NS : T_CP_NS) + CLK_NS - 1)
        / CLK_NS;
    localparam int C_RHCP = (T_RHCP_NS + CLK_NS - 1) / CLK_NS;
    localparam int C_HOLD = (C_RHCP > C_CPRE) ? C_RHCP - C_CPRE : 1;
    localparam int C_CSR = (T_CSR_NS + CLK_NS - 1) / CLK_NS;
    localparam int C_CHR = (T_CHR_NS + CLK_NS - 1) / CLK_NS;
    localparam int C_RPS = (T_RPS_NS + CLK_NS - 1) / CLK_NS;
    localparam int C_INIT = T_INIT_US * 1000 / CLK_NS;
    localparam int C_RASS = T_RASS_US * 1000 / CLK_NS;
    localparam int PAGE_MARGIN = 64;

    // ****************************************
    // Refresh figures
    // ****************************************
    localparam int ROWS = 4096;
    localparam int INIT_CYCLES = 8;
    localparam int C_REF_INTERVAL = T_REF_MS * 1000000 / CLK_NS / ROWS;

    // ****************************************
    // Sequencer states
    // ****************************************
    typedef enum logic [3:0] {
        S_IDLE = 4'h0,
        S_ROW = 4'h1,
        S_COLSET = 4'h3,
        S_CAS = 4'h2,
        S_CPRE = 4'h6,
        S_HOLD = 4'h7,
        S_PRE = 4'h5,
        S_INIT = 4'h4,
        S_CSR = 4'hc,
        S_REF = 4'hd
    } edoc_state_t;

endpackage : edoc_pkg

// [hdl/edoc_ref_if.sv]
// Purpose: Refresh request and acknowledge between timer and sequencer.
// Assumes: Both ends run on the controller clock.
// Notes: Due is a level; ack is a one-cycle pulse.
`timescale 1ns/1ps
`default_nettype none
interface edoc_ref_if;
    logic due;
    logic ack;
    modport timer (output due, input ack);
    modport ctrl (input due, output ack);
endinterface : edoc_ref_if
`default_nettype wire

// [hdl/edoc_ref_timer.sv]
// Purpose: Countdown that spaces refresh cycles evenly over the refresh time.
// Assumes: One refresh per acknowledge.
// Notes: A due that arises in the cycle of an ack stays set.
`timescale 1ns/1ps
`default_nettype none
module edoc_ref_timer
    import edoc_pkg::*;
#(
    parameter int INTERVAL_CYC = C_REF_INTERVAL
)(
    input wire logic clk,
    input wire logic nrst,
    edoc_ref_if.timer ref_port
);
    logic [CNT_W-1:0] count;
    logic due;
    wire expire = (count == '0);
    wire [CNT_W-1:0] next_count = expire ? CNT_W'(INTERVAL_CYC - 1) : count - 1'b1;

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            count <= '0;
            due <= 1'b0;
        end
        else
        begin
            count <= next_count;
            due <= expire | (due & ~ref_port.ack);
        end
    end

    assign ref_port.due = due;
endmodule : edoc_ref_timer
`default_nettype wire

// [testbench/edo_dram_strobe_timing_tb_top.sv]
// Purpose: Self-checking bench for the DRAM strobe controller.
// Assumes: Long counts shortened through parameters.
// Notes: Read data is compared on enabled byte lanes only.
`timescale 1ns/1ps
`default_nettype none
module edo_dram_strobe_timing_tb_top
    import edoc_pkg::*;
;
    localparam int INIT_W = 50;
    localparam int SR_MIN = 40;
    localparam int REF_INT = 100;
    localparam int BURST = 4;
    logic clk = 1'h0;
    logic nrst = 1'h0;
    logic req_valid = 1'h0;
    logic req_write = 1'h0;
    logic [ROW_W-1:0] req_row = 12'h000;
    logic [COL_W-1:0] req_col = 10'h000;
    logic [1:0] req_be = 2'h0;
    logic [DATA_W-1:0] req_wdata = 16'h0000;
    logic self_refresh_req = 1'h0;
    logic req_ready, rsp_valid, self_refresh_active, init_done, data_pins_oe;
    logic row_strobe_n, lower_byte_strobe_n, upper_byte_strobe_n, write_n, out_en_n;
    logic [ROW_W-1:0] addr;
    logic [DATA_W-1:0] rsp_rdata, data_pins_o, dram_q;
    logic [DATA_W-1:0] bmem [int];
    wire [DATA_W-1:0] pins;
    int mismatches = 0;
    int check_count = 0;
    int refs = 0;
    int low_run = 0;
    int n = 0;
    int seed = 32'h0000_a381;
    assign pins = data_pins_oe ? data_pins_o : dram_q;
    initial forever #5 clk = ~clk;
    edoc_ctrl #(.INIT_WAIT_CYC(INIT_W), .SR_MIN_CYC(SR_MIN), .RASP_MAX_CYC(200),
        .REF_INTERVAL_CYC(REF_INT), .BURST_ROWS(BURST)) DUT (.clk, .nrst, .req_valid,
        .req_ready, .req_write, .req_row, .req_col, .req_be, .req_wdata, .rsp_valid,
        .rsp_rdata, .self_refresh_req, .self_refresh_active, .init_done, .row_strobe_n,
        .lower_byte_strobe_n, .upper_byte_strobe_n, .write_n, .out_en_n, .addr,
        .data_pins_i(pins), .data_pins_o, .data_pins_oe);
    edoc_dram_model u_dram (.row_strobe_n, .lower_byte_strobe_n, .upper_byte_strobe_n,
        .write_n, .out_en_n, .addr, .pins, .dram_q);
    // Refreshes are told apart by a column strobe already low at the row fall.
    always @(posedge clk)
    begin
        if (nrst && $fell(row_strobe_n) && !lower_byte_strobe_n)
            refs++;
        low_run = row_strobe_n ? 0 : low_run + 1;
    end
    // **********
    // Tasks
    // **********
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : wrap_up
    task automatic chk_val(input string s, input logic [15:0] e, input logic [15:0] g);
        check_count++;
        if (g !== e)
        begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", s, e, g);
        end
    endtask : chk_val
    task automatic chk_cnt(input string s, input int lo, input int hi, input int g);
        check_count++;
        if (g < lo || g > hi)
        begin
            mismatches++;
            $display("ERROR %s expected %0d..%0d seen %0d", s, lo, hi, g);
        end
    endtask : chk_cnt
    task automatic tick(inout int w, input int lim);
        @(posedge clk);
        #1;
        w++;
        if (w > lim)
        begin
            $display("ERROR wait expected %0d seen %0d", lim, w);
            mismatches++;
            wrap_up();
        end
    endtask : tick
    task automatic do_req(input logic wr, input logic [ROW_W-1:0] r, input logic [1:0] be);
        int w;
        logic [COL_W-1:0] c;
        logic [DATA_W-1:0] d;
        logic [DATA_W-1:0] e;
        logic [DATA_W-1:0] m;
        w = 0;
        c = COL_W'($random(seed) & 32'h0000_0007);
        d = DATA_W'($random(seed));
        req_write = wr;
        req_row = r;
        req_col = c;
        req_be = be;
        req_wdata = d;
        req_valid = 1'h1;
        #1;
        while (req_ready !== 1'h1) tick(w, 300);
        tick(w, 300);
        req_valid = 1'h0;
        w = 0;
        while (rsp_valid !== 1'h1) tick(w, 40);
        m = {{8{be[1]}}, {8{be[0]}}};
        e = bmem.exists(int'({r, c})) ? bmem[int'({r, c})] : 16'h0000;
        if (wr)
            bmem[int'({r, c})] = (e & ~m) | (d & m);
        else
            chk_val("rdata", e & m, rsp_rdata & m);
    endtask : do_req
    // **********
    // Sequence
    // **********
    initial
    begin
        repeat (6) @(posedge clk);
        chk_val("reset_pins", 16'h00f8, {8'h00, row_strobe_n, lower_byte_strobe_n,
            upper_byte_strobe_n, write_n, out_en_n, data_pins_oe, req_ready, init_done});
        #1 nrst = 1'h1;
        while (init_done !== 1'h1) tick(n, 2000);
        chk_cnt("init_wait", INIT_W, 2000, n);
        chk_cnt("init_refs", 8, 9, refs);
        $display("test init done");
        for (int i = 0; i < 60; i++)
            do_req(1'($random(seed)), ROW_W'($random(seed) & 32'h0000_0001), 2'(i));
        $display("test traffic done");
        refs = 0;
        n = 0;
        while (n < 1000) tick(n, 1000);
        chk_cnt("idle_refs", 1000 / REF_INT - 1, 1000 / REF_INT + 1, refs);
        $display("test refresh done");
        self_refresh_req = 1'h1;
        n = 0;
        while (self_refresh_active !== 1'h1) tick(n, 500);
        chk_cnt("sr_low", SR_MIN - 1, SR_MIN + 4, low_run);
        repeat (20) @(posedge clk);
        #1 self_refresh_req = 1'h0;
        n = 0;
        while (row_strobe_n !== 1'h1) tick(n, 100);
        n = 0;
        refs = 0;
        while (row_strobe_n === 1'h1) tick(n, 100);
        chk_cnt("sr_exit_gap", 9, 100, n);
        n = 0;
        while (init_done !== 1'h1) tick(n, 500);
        chk_cnt("burst_refs", BURST, BURST + 1, refs);
        $display("test self refresh done");
        for (int i = 0; i < 20; i++)
            do_req(1'h0, ROW_W'($random(seed) & 32'h0000_0001), 2'h3);
        $display("test read back done");
        wrap_up();
    end
endmodule : edo_dram_strobe_timing_tb_top
`default_nettype wire

// [testbench/edoc_ctrl_properties.sv]
// Purpose: Pin timing checks for the DRAM controller.
// Assumes: 100 MHz clock and the faster timing grade.
// Notes: Sees only controller ports; bound at the foot.
`timescale 1ns/1ps
`default_nettype none
module edoc_ctrl_properties
    import edoc_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic row_strobe_n,
    input wire logic lower_byte_strobe_n,
    input wire logic upper_byte_strobe_n,
    input wire logic write_n,
    input wire logic out_en_n,
    input wire logic [DATA_W-1:0] data_pins_o,
    input wire logic data_pins_oe
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    property p_rp;
        $rose(row_strobe_n) |-> row_strobe_n [*3];
    endproperty
    a_rp: assert property (p_rp) else $error("row precharge short");
    property p_ras;
        $fell(row_strobe_n) |-> !row_strobe_n [*5];
    endproperty
    a_ras: assert property (p_ras) else $error("row active short");
    property p_cbr;
        $fell(row_strobe_n) && !(lower_byte_strobe_n && upper_byte_strobe_n)
            |-> !$past(lower_byte_strobe_n) && !$past(upper_byte_strobe_n) && write_n
            ##1 !lower_byte_strobe_n && !upper_byte_strobe_n;
    endproperty
    a_cbr: assert property (p_cbr) else $error("refresh setup or hold");
    property p_rcd;
        $fell(row_strobe_n) && lower_byte_strobe_n
            |-> (lower_byte_strobe_n && upper_byte_strobe_n) [*2];
    endproperty
    a_rcd: assert property (p_rcd) else $error("column strobe early");
    property p_wcs;
        $fell(lower_byte_strobe_n) && !write_n |-> !$past(write_n);
    endproperty
    a_wcs: assert property (p_wcs) else $error("write strobe late");
    property p_cwl;
        $rose(lower_byte_strobe_n) && !$past(write_n) |-> !$past(write_n, 2);
    endproperty
    a_cwl: assert property (p_cwl) else $error("write strobe short");
    property p_oed;
        $rose(data_pins_oe) |-> $past(out_en_n) && $past(out_en_n, 2);
    endproperty
    a_oed: assert property (p_oed) else $error("data driven early");
    property p_din;
        !lower_byte_strobe_n && !write_n |-> data_pins_oe && $stable(data_pins_o);
    endproperty
    a_din: assert property (p_din) else $error("write data moved");
    property p_rhcp;
        $rose(lower_byte_strobe_n) && !row_strobe_n |-> !row_strobe_n [*3];
    endproperty
    a_rhcp: assert property (p_rhcp) else $error("row released early");
endmodule : edoc_ctrl_properties
bind edoc_ctrl edoc_ctrl_properties u_props (.clk, .nrst, .row_strobe_n,
    .lower_byte_strobe_n, .upper_byte_strobe_n, .write_n, .out_en_n,
    .data_pins_o, .data_pins_oe);
`default_nettype wire

// [testbench/edoc_dram_model.sv]
// Purpose: Behavioural DRAM seen through its strobe pins.
// Assumes: Faster grade access times; contents start at zero.
// Notes: Undriven lanes toggle so a stale value never passes.
`timescale 1ns/1ps
`default_nettype none
module edoc_dram_model
    import edoc_pkg::*;
(
    input wire logic row_strobe_n,
    input wire logic lower_byte_strobe_n,
    input wire logic upper_byte_strobe_n,
    input wire logic write_n,
    input wire logic out_en_n,
    input wire logic [ROW_W-1:0] addr,
    input wire logic [DATA_W-1:0] pins,
    output logic [DATA_W-1:0] dram_q
);
    logic [DATA_W-1:0] mem [int];
    logic [DATA_W-1:0] junk = 16'h5a5a;
    logic [DATA_W-1:0] word;
    logic [ROW_W-1:0] row = 12'h000;
    logic rac_ok = 1'h0;
    logic cas_ok = 1'h0;
    logic on;
    int key = 0;
    always #7 junk = ~junk;
    // A refresh cycle must not disturb the latched row.
    always @(negedge row_strobe_n)
    begin
        if (lower_byte_strobe_n && upper_byte_strobe_n)
            row = addr;
        rac_ok = 1'h0;
        #50 rac_ok = 1'h1;
    end
    always @(negedge lower_byte_strobe_n or negedge upper_byte_strobe_n)
    begin
        cas_ok = 1'h0;
        key = int'({row, addr[COL_W-1:0]});
        if (!mem.exists(key))
            mem[key] = 16'h0000;
        if (!row_strobe_n && !write_n && !lower_byte_strobe_n)
            mem[key][7:0] = pins[7:0];
        if (!row_strobe_n && !write_n && !upper_byte_strobe_n)
            mem[key][15:8] = pins[15:8];
        #13 cas_ok = 1'h1;
    end
    always #1
    begin
        word = mem.exists(key) ? mem[key] : 16'h0000;
        on = rac_ok && cas_ok && !row_strobe_n && !out_en_n && write_n;
        dram_q[7:0] = (on && !lower_byte_strobe_n) ? word[7:0] : junk[7:0];
        dram_q[15:8] = (on && !upper_byte_strobe_n) ? word[15:8] : junk[15:8];
    end
endmodule : edoc_dram_model
`default_nettype wire
